// *** mipc_cpu.sv ***
// CPU-side interrupt sequencer: acceptance, 20-cycle entry, return restore.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`include "mipc_defs.svh"
module mipc_cpu
  import mipc_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // Sequencer control
  input  wire logic        i_instr_done,
  input  wire logic        i_instr_suspendable,
  input  wire logic        i_special_req,
  input  wire logic [5:0]  i_special_num,
  input  wire logic        i_swi,
  input  wire logic [5:0]  i_swi_num,
  input  wire logic        i_return_from_interrupt_instr,
  input  wire logic [19:0] i_pc,
  input  wire logic [7:0]  i_flags,
  input  wire logic        i_flags_wr,
  input  wire logic [23:0] i_vector,
  input  wire logic [31:0] i_pop_data,
  // Software register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  // Memory and sequencing outputs
  output logic             o_info_rd,
  output logic      [19:0] o_info_addr,
  output logic             o_stack_wr,
  output logic      [7:0]  o_stack_byte,
  output logic      [1:0]  o_stack_idx,
  output logic             o_entry_busy,
  output logic             o_handler_start,
  output logic      [19:0] o_pc,
  output logic      [7:0]  o_flags,
  output logic      [2:0]  o_ipl,
  // Link to device
  mipc_if.cpu              lnk
);
  typedef enum logic [1:0] {MIPC_IDLE, MIPC_ENTRY} mipc_st_type;

  mipc_st_type  st_r;
  logic [4:0]   cnt_r;
  logic [7:0]   flags_r, tmp_r;
  logic [2:0]   ipl_r, new_ipl_r;
  logic [19:0]  pc_r;
  logic [15:0]  word_hi, word_lo;
  logic         ack_r, info_r, swr_r, hs_r;
  logic         busy_r;
  logic [5:0]   ack_num_r;
  logic [7:0]   sbyte_r, rd_r;
  logic [1:0]   sidx_r;
  mipc_kind_type kind_r;

  localparam logic [4:0] LAST = 5'(`MIPC_ENTRY_CYCLES - 1);

  // --------------------------------------------------------------------------
  // Acceptance
  // --------------------------------------------------------------------------
  logic start_swi, start_spc, start_msk, can_eval;
  assign can_eval  = (st_r == MIPC_IDLE) && (i_instr_done || i_instr_suspendable);
  assign start_swi = (st_r == MIPC_IDLE) && i_swi;
  assign start_spc = can_eval && !start_swi && i_special_req;
  assign start_msk = can_eval && !start_swi && !i_special_req && lnk.req &&
                     flags_r[`MIPC_FLG_I] && lnk.req_lvl > ipl_r;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r      <= MIPC_IDLE;
      cnt_r     <= 5'h00;
      kind_r    <= MIPC_KIND_MASKABLE;
      ack_num_r <= 6'h00;
      new_ipl_r <= 3'h0;
      busy_r    <= 1'b0;
    end else if (st_r == MIPC_IDLE) begin
      cnt_r <= 5'h00;
      if (start_swi || start_spc || start_msk) begin
        st_r      <= MIPC_ENTRY;
        busy_r    <= 1'b1;
        ack_num_r <= start_swi ? i_swi_num : start_spc ? i_special_num : lnk.req_num;
        kind_r    <= start_swi ? MIPC_KIND_SOFTWARE : start_spc ? MIPC_KIND_SPECIAL
                                                                 : MIPC_KIND_MASKABLE;
        new_ipl_r <= start_spc ? `MIPC_IPL_SPECIAL : start_swi ? ipl_r : lnk.req_lvl;
      end
    end else begin
      cnt_r <= cnt_r + 5'h01;
      if (cnt_r == LAST) begin
        st_r   <= MIPC_IDLE;
        busy_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Entry steps
  // --------------------------------------------------------------------------
  // The stacked word carries the flags as they stood before entry cleared them.
  assign word_hi = {pc_r[19:16], 1'b0, ipl_r, tmp_r};
  assign word_lo = pc_r[15:0];

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_r   <= 1'b0;
      info_r  <= 1'b0;
      swr_r   <= 1'b0;
      sbyte_r <= 8'h00;
      sidx_r  <= 2'h0;
      hs_r    <= 1'b0;
    end else begin
      ack_r  <= (st_r == MIPC_ENTRY) && cnt_r == 5'h00 && kind_r == MIPC_KIND_MASKABLE;
      info_r <= (st_r == MIPC_ENTRY) && cnt_r == 5'h00;
      swr_r  <= (st_r == MIPC_ENTRY) && cnt_r >= 5'h04 && cnt_r <= 5'h07;
      sidx_r <= cnt_r[1:0];
      unique case (cnt_r[1:0])
        2'h0: sbyte_r <= word_hi[15:8];
        2'h1: sbyte_r <= word_hi[7:0];
        2'h2: sbyte_r <= word_lo[15:8];
        2'h3: sbyte_r <= word_lo[7:0];
      endcase
      hs_r   <= (st_r == MIPC_ENTRY) && cnt_r == LAST;
    end
  end

  // Flags, PROCESSOR_PRIORITY_LEVEL and PC are separate state so no update disturbs another.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_r <= 8'h00;
      tmp_r   <= 8'h00;
      ipl_r   <= 3'h0;
      pc_r    <= 20'h0_0000;
    end else if (st_r == MIPC_ENTRY) begin
      if (cnt_r == 5'h01) begin
        tmp_r <= flags_r;
        flags_r[`MIPC_FLG_I] <= 1'b0;
        flags_r[`MIPC_FLG_D] <= 1'b0;
        if (!(kind_r == MIPC_KIND_SOFTWARE && ack_num_r >= `MIPC_SWI_U_KEEP_LO)) begin
          flags_r[`MIPC_FLG_U] <= 1'b0;
        end
      end
      if (cnt_r == 5'h08) begin
        ipl_r <= new_ipl_r;
      end
      if (cnt_r == LAST) begin
        pc_r <= i_vector[19:0];
      end
    end else if (i_return_from_interrupt_instr) begin
      flags_r <= i_pop_data[23:16];
      ipl_r   <= i_pop_data[26:24];
      pc_r    <= {i_pop_data[31:28], i_pop_data[15:0]};
    end else begin
      pc_r <= i_pc;
      if (i_flags_wr) begin
        flags_r <= i_flags;
      end else if (i_reg_wr && i_reg_addr == `MIPC_OFS_CPU_FLAGS) begin
        flags_r <= i_reg_wdata;
      end
      if (i_reg_wr && i_reg_addr == `MIPC_OFS_CPU_STAT) begin
        ipl_r <= i_reg_wdata[2:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Software register port
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_r <= 8'h00;
    end else if (!i_reg_rd) begin
      rd_r <= 8'h00;
    end else if (i_reg_addr == `MIPC_OFS_CPU_FLAGS) begin
      rd_r <= flags_r;
    end else if (i_reg_addr == `MIPC_OFS_CPU_STAT) begin
      rd_r <= {4'h0, st_r == MIPC_ENTRY, ipl_r};
    end else begin
      rd_r <= lnk.ctl_rdata;
    end
  end

  assign lnk.ack       = ack_r;
  assign lnk.ack_num   = ack_num_r;
  assign lnk.processor_priority_level       = ipl_r;
  assign lnk.gie       = flags_r[`MIPC_FLG_I];
  assign lnk.ctl_wr    = i_reg_wr;
  assign lnk.ctl_rd    = i_reg_rd;
  assign lnk.ctl_addr  = i_reg_addr;
  assign lnk.ctl_wdata = i_reg_wdata & 8'hdf;

  assign o_reg_rdata     = rd_r;
  assign o_info_rd       = info_r;
  assign o_info_addr     = `MIPC_INFO_ADDR;
  assign o_stack_wr      = swr_r;
  assign o_stack_byte    = sbyte_r;
  assign o_stack_idx     = sidx_r;
  assign o_entry_busy    = busy_r;
  assign o_handler_start = hs_r;
  assign o_pc            = pc_r;
  assign o_flags         = flags_r;
  assign o_ipl           = ipl_r;
endmodule

// *** mipc_defs.svh ***
// Constants for the maskable interrupt priority controller.
`ifndef MIPC_DEFS_SVH
`define MIPC_DEFS_SVH
`define MIPC_OFS_LINE5      8'h45
`define MIPC_OFS_LINE2      8'h55
`define MIPC_OFS_LINE1      8'h59
`define MIPC_OFS_LINE3      8'h5a
`define MIPC_OFS_LINE0      8'h5d
`define MIPC_OFS_CPU_FLAGS  8'hf0
`define MIPC_OFS_CPU_STAT   8'hf1
`define MIPC_OFS_CPU_CMD    8'hf2
`define MIPC_BIT_LVL_LO     0
`define MIPC_BIT_LVL_HI     2
`define MIPC_BIT_PEND       3
`define MIPC_BIT_POL        4
`define MIPC_BIT_RSVD       5
`define MIPC_FLG_I          6
`define MIPC_FLG_D          5
`define MIPC_FLG_U          7
`define MIPC_ENTRY_CYCLES   20
`define MIPC_INFO_ADDR      20'h0_0000
`define MIPC_IPL_SPECIAL    3'h7
`define MIPC_SWI_U_KEEP_LO  6'h20
`define MIPC_NSRC           5
`endif

// *** mipc_pkg.sv ***
// Types shared by both ends of the interrupt controller link.
package mipc_pkg;
  typedef enum logic [1:0] {
    MIPC_KIND_MASKABLE,
    MIPC_KIND_SPECIAL,
    MIPC_KIND_SOFTWARE,
    MIPC_KIND_NOCHANGE
  } mipc_kind_type;
endpackage

// *** mipc_if.sv ***
// Link between the interrupt controller and the CPU sequencer.
`timescale 1ns/100ps
interface mipc_if;
  logic       req;
  logic [2:0] req_lvl;
  logic [5:0] req_num;
  logic       ack;
  logic [5:0] ack_num;
  logic [2:0] processor_priority_level;
  logic       gie;
  logic       ctl_wr;
  logic [7:0] ctl_addr;
  logic [7:0] ctl_wdata;
  logic [7:0] ctl_rdata;
  logic       ctl_rd;
  modport dev (output req, req_lvl, req_num, ctl_rdata,
               input ack, ack_num, processor_priority_level, gie, ctl_wr, ctl_rd, ctl_addr, ctl_wdata);
  modport cpu (input req, req_lvl, req_num, ctl_rdata,
               output ack, ack_num, processor_priority_level, gie, ctl_wr, ctl_rd, ctl_addr, ctl_wdata);
endinterface

// *** mipc_dev.sv ***
// Per-line interrupt control registers with edge detection and request arbitration.
`timescale 1ns/100ps
`include "mipc_defs.svh"
module mipc_dev
  import mipc_pkg::*;
#(
  parameter int NSRC = `MIPC_NSRC
) (
  // Clock and reset
  input  wire logic            i_mclk,
  input  wire logic            i_rst_n,
  // External lines and both-edge selects
  input  wire logic [NSRC-1:0] i_ext_line,
  input  wire logic [NSRC-1:0] i_both_edge_select,
  // Link to CPU
  mipc_if.dev                  lnk
);
  localparam logic [7:0] OFS [0:4] = '{`MIPC_OFS_LINE0, `MIPC_OFS_LINE1, `MIPC_OFS_LINE2,
                                       `MIPC_OFS_LINE3, `MIPC_OFS_LINE5};
  localparam logic [5:0] VEC [0:4] = '{6'h1d, 6'h19, 6'h15, 6'h1a, 6'h05};

  logic [NSRC-1:0] s1_r, s2_r, s3_r;
  logic [2:0]      lvl_r [NSRC];
  logic [NSRC-1:0] pend_r, pol_r, rsvd_r;
  logic [7:0]      rdata;
  logic            req_r;
  logic [2:0]      req_lvl_r;
  logic [5:0]      req_num_r;

  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : gen_src
      logic hit, edge_ev, wr_hit, ack_hit;
      assign hit     = lnk.ctl_wr && (lnk.ctl_addr == OFS[g]);
      assign wr_hit  = hit;
      assign ack_hit = lnk.ack && (lnk.ack_num == VEC[g]);
      // Edge select: both edges, else rising when polarity set, else falling.
      assign edge_ev = i_both_edge_select[g] ? (s2_r[g] ^ s3_r[g]) :
                       pol_r[g] ? (s2_r[g] & ~s3_r[g]) : (~s2_r[g] & s3_r[g]);
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          lvl_r[g]  <= 3'h0;
          pol_r[g]  <= 1'b0;
          rsvd_r[g] <= 1'b0;
        end else if (wr_hit) begin
          lvl_r[g]  <= lnk.ctl_wdata[`MIPC_BIT_LVL_HI:`MIPC_BIT_LVL_LO];
          pol_r[g]  <= lnk.ctl_wdata[`MIPC_BIT_POL];
          rsvd_r[g] <= lnk.ctl_wdata[`MIPC_BIT_RSVD];
        end
      end
      // A new edge wins over a software clear or an acceptance clear.
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          pend_r[g] <= 1'b0;
        end else if (edge_ev) begin
          pend_r[g] <= 1'b1;
        end else if (ack_hit) begin
          pend_r[g] <= 1'b0;
        end else if (wr_hit && !lnk.ctl_wdata[`MIPC_BIT_PEND]) begin
          pend_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Line sampling
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // The lines idle high, so the history starts high and no false edge follows reset.
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= i_ext_line;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // --------------------------------------------------------------------------
  // Arbitration: highest level wins, ties go to the lower vector number.
  // --------------------------------------------------------------------------
  logic       best_v;
  logic [2:0] best_l;
  logic [5:0] best_n;
  always_comb begin
    best_v = 1'b0;
    best_l = 3'h0;
    best_n = 6'h00;
    for (int k = 0; k < NSRC; k++) begin
      if (pend_r[k] && lvl_r[k] != 3'h0 && lvl_r[k] > lnk.processor_priority_level &&
          lnk.gie && !(lnk.ack && lnk.ack_num == VEC[k])) begin
        if (!best_v || lvl_r[k] > best_l ||
            (lvl_r[k] == best_l && VEC[k] < best_n)) begin
          best_v = 1'b1;
          best_l = lvl_r[k];
          best_n = VEC[k];
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_r     <= 1'b0;
      req_lvl_r <= 3'h0;
      req_num_r <= 6'h00;
    end else begin
      req_r     <= best_v;
      req_lvl_r <= best_l;
      req_num_r <= best_n;
    end
  end

  // --------------------------------------------------------------------------
  // Register reads; bits 7:6 read as zero.
  // --------------------------------------------------------------------------
  // Read data answer in the strobe's own cycle, so that the CPU end can register
  // them and still keep its one-cycle read latency.
  always_comb begin
    rdata = 8'h00;
    for (int k = 0; k < NSRC; k++) begin
      if (lnk.ctl_rd && lnk.ctl_addr == OFS[k]) begin
        rdata = {2'b00, rsvd_r[k], pol_r[k], pend_r[k], lvl_r[k]};
      end
    end
  end

  assign lnk.req       = req_r;
  assign lnk.req_lvl   = req_lvl_r;
  assign lnk.req_num   = req_num_r;
  assign lnk.ctl_rdata = rdata;
endmodule

// *** mipc_chk.sv ***
// Concurrent checks on the link between the interrupt controller ends.
`timescale 1ns/100ps
module mipc_chk (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  // Link signals
  input  wire logic       req,
  input  wire logic [2:0] req_lvl,
  input  wire logic [5:0] req_num,
  input  wire logic       ack,
  input  wire logic [5:0] ack_num,
  input  wire logic [2:0] processor_priority_level,
  input  wire logic       gie,
  input  wire logic       ctl_wr,
  input  wire logic [7:0] ctl_addr,
  input  wire logic [7:0] ctl_rdata
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  // ----------
  // Properties
  // ----------
  sequence s_quiet;
    !ack [*8];
  endsequence
  property p_lvl_nonzero;
    req |-> req_lvl != 3'h0;
  endproperty
  a_lvl_nonzero: assert property (p_lvl_nonzero) else $error("request raised at level zero");
  property p_src_known;
    req |-> req_num inside {6'h05, 6'h15, 6'h19, 6'h1a, 6'h1d};
  endproperty
  a_src_known: assert property (p_src_known) else $error("request names an unknown source");
  property p_rsvd_zero;
    ctl_rdata[7:5] == 3'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read as one");
  property p_ipl_block;
    (processor_priority_level == 3'h7) [*4] |-> !ack;
  endproperty
  a_ipl_block: assert property (p_ipl_block) else $error("acceptance while all levels blocked");
  property p_gie_block;
    (!gie) [*4] |-> !ack;
  endproperty
  a_gie_block: assert property (p_gie_block) else $error("acceptance with global enable low");
  // The answer may land two or three edges after the accepting edge.
  property p_ack_cause;
    ack |-> ($past(req, 2) && $past(gie, 2) && $past(req_lvl, 2) > $past(processor_priority_level, 2) && $past(req_num, 2) == ack_num)
         || ($past(req, 3) && $past(gie, 3) && $past(req_lvl, 3) > $past(processor_priority_level, 3) && $past(req_num, 3) == ack_num);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("acceptance without an eligible winner");
  property p_entry_quiet;
    ack |=> s_quiet ##1 s_quiet;
  endproperty
  a_entry_quiet: assert property (p_entry_quiet) else $error("second acceptance during entry");
  property p_indep;
    ctl_wr && ctl_addr[7:4] != 4'hf |=> $stable(processor_priority_level) && $stable(gie);
  endproperty
  a_indep: assert property (p_indep) else $error("control write disturbed level or enable");
endmodule

// *** maskable_irq_priority_control_tb.sv ***
// Bench joining the device and CPU ends of the interrupt controller.
`timescale 1ns/100ps
`include "mipc_defs.svh"
module maskable_irq_priority_control_tb;
  logic        i_mclk = 1'h0, i_rst_n = 1'h0, i_instr_done = 1'h0, i_instr_suspendable = 1'h0;
  logic        i_special_req = 1'h0, i_swi = 1'h0, i_return_from_interrupt_instr = 1'h0, i_flags_wr = 1'h0, i_reg_wr = 1'h0;
  logic        i_reg_rd = 1'h0, o_info_rd, o_stack_wr, o_entry_busy, o_handler_start, info_seen;
  logic [4:0]  i_ext_line = 5'h1f, i_both_edge_select = 5'h08;
  logic [5:0]  i_special_num = 6'h00, i_swi_num = 6'h00, got_num;
  logic [19:0] i_pc = 20'h5_1234, o_info_addr, o_pc;
  logic [23:0] i_vector = 24'h00_0abc;
  logic [31:0] i_pop_data = 32'h0000_0000;
  logic [7:0]  i_flags = 8'h00, i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, o_stack_byte, o_flags;
  logic [7:0]  stk [4];
  logic [2:0]  o_ipl;
  logic [1:0]  o_stack_idx;
  int          num_checks = 0;
  int          fail_count = 0;
  mipc_if bus ();
  mipc_dev i_mipc_dev (.i_mclk, .i_rst_n, .i_ext_line, .i_both_edge_select, .lnk(bus));
  mipc_cpu i_mipc_cpu (
    .i_mclk, .i_rst_n, .i_instr_done, .i_instr_suspendable, .i_special_req, .i_special_num, .i_swi, .i_swi_num,
    .i_return_from_interrupt_instr, .i_pc, .i_flags, .i_flags_wr, .i_vector, .i_pop_data, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .o_info_rd, .o_info_addr, .o_stack_wr, .o_stack_byte, .o_stack_idx, .o_entry_busy,
    .o_handler_start, .o_pc, .o_flags, .o_ipl, .lnk(bus));
  mipc_chk i_mipc_chk (
    .i_mclk, .i_rst_n, .req(bus.req), .req_lvl(bus.req_lvl), .req_num(bus.req_num), .ack(bus.ack),
    .ack_num(bus.ack_num), .processor_priority_level(bus.processor_priority_level), .gie(bus.gie), .ctl_wr(bus.ctl_wr), .ctl_addr(bus.ctl_addr),
    .ctl_rdata(bus.ctl_rdata));
  // -------
  // Helpers
  // -------
  initial begin
    forever #50 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    if (o_stack_wr) stk[o_stack_idx] <= o_stack_byte;
    if (o_info_rd && o_info_addr === 20'h0_0000) info_seen <= 1'h1;
    if (bus.ack) got_num <= bus.ack_num;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_wr    <= 1'h1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_mclk);
    i_reg_wr <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_reg_rd   <= 1'h1;
    i_reg_addr <= a;
    @(posedge i_mclk);
    i_reg_rd <= 1'h0;
    #1 check(o_reg_rdata, e);
  endtask
  task automatic fl(input logic [7:0] f);
    @(posedge i_mclk);
    i_flags    <= f;
    i_flags_wr <= 1'h1;
    @(posedge i_mclk);
    i_flags_wr <= 1'h0;
  endtask
  task automatic fall(input int i);
    @(posedge i_mclk);
    i_ext_line[i] <= 1'h1;
    repeat (2) @(posedge i_mclk);
    i_ext_line[i] <= 1'h0;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic go(input logic s);
    @(posedge i_mclk);
    i_instr_done        <= ~s;
    i_instr_suspendable <= s;
    @(posedge i_mclk);
    i_instr_done        <= 1'h0;
    i_instr_suspendable <= 1'h0;
  endtask
  task automatic none;
    repeat (4) @(posedge i_mclk);
    #1 check(o_entry_busy, 1'h0);
  endtask
  task automatic entry(input logic [2:0] lvl, input logic [7:0] fexp);
    int n;
    #1 n = 0;
    while (o_entry_busy !== 1'h1 && n < 8) begin
      @(posedge i_mclk);
      #1 n++;
    end
    n = 0;
    while (o_handler_start !== 1'h1 && n < 40) begin
      @(posedge i_mclk);
      #1 n++;
    end
    check(n, 20);
    check(o_pc, 20'h0_0abc);
    check(o_ipl, lvl);
    check(o_flags & 8'he0, fexp);
  endtask
  task automatic ret;
    int n;
    @(posedge i_mclk);
    i_pop_data <= 32'h5040_1234;
    i_return_from_interrupt_instr     <= 1'h1;
    @(posedge i_mclk);
    i_return_from_interrupt_instr <= 1'h0;
    #1 n = 0;
    while (o_pc !== 20'h5_1234 && n < 8) begin
      @(posedge i_mclk);
      #1 n++;
    end
    check({o_pc, o_flags, 1'h0, o_ipl}, 32'h5_1234_40_0);
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic t_regs;
    rchk(`MIPC_OFS_LINE0, 8'h00);
    wr(`MIPC_OFS_LINE0, 8'hff);
    wr(`MIPC_OFS_LINE0, 8'hf7);
    rchk(`MIPC_OFS_LINE0, 8'h17);
    wr(`MIPC_OFS_LINE0, 8'h00);
    rchk(8'h60, 8'h00);
  endtask
  task automatic t_accept;
    wr(`MIPC_OFS_LINE1, 8'h03);
    fl(8'h40);
    fall(1);
    rchk(`MIPC_OFS_LINE1, 8'h0b);
    info_seen = 1'h0;
    go(1'h0);
    entry(3'h3, 8'h00);
    check(info_seen, 1'h1);
    check({stk[0], stk[1], stk[2], stk[3]}, 32'h5040_1234);
    rchk(`MIPC_OFS_LINE1, 8'h03);
    ret;
  endtask
  task automatic t_block;
    fall(1);
    wr(`MIPC_OFS_CPU_STAT, 8'h03);
    go(1'h0);
    none;
    wr(`MIPC_OFS_CPU_STAT, 8'h07);
    go(1'h0);
    none;
    wr(`MIPC_OFS_CPU_STAT, 8'h02);
    fl(8'h00);
    go(1'h0);
    none;
    fl(8'h40);
    go(1'h0);
    entry(3'h3, 8'h00);
    ret;
  endtask
  task automatic t_arb;
    wr(`MIPC_OFS_LINE1, 8'h04);
    wr(`MIPC_OFS_LINE3, 8'h05);
    fall(1);
    fall(3);
    go(1'h0);
    entry(3'h5, 8'h00);
    check(got_num, 6'h1a);
    ret;
    wr(`MIPC_OFS_LINE3, 8'h04);
    @(posedge i_mclk);
    i_ext_line[3] <= 1'h1;
    repeat (4) @(posedge i_mclk);
    go(1'h1);
    entry(3'h4, 8'h00);
    check(got_num, 6'h19);
    ret;
    go(1'h0);
    entry(3'h4, 8'h00);
    check(got_num, 6'h1a);
    ret;
  endtask
  task automatic t_soft;
    for (int k = 0; k < 2; k++) begin
      fl(8'h80);
      @(posedge i_mclk);
      i_swi     <= 1'h1;
      i_swi_num <= k ? 6'h05 : 6'h28;
      @(posedge i_mclk);
      i_swi <= 1'h0;
      entry(3'h0, k ? 8'h00 : 8'h80);
      ret;
    end
  endtask
  task automatic t_spec;
    @(posedge i_mclk);
    i_special_req <= 1'h1;
    i_special_num <= 6'h32;
    go(1'h0);
    i_special_req <= 1'h0;
    entry(3'h7, 8'h00);
    ret;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'h1;
    t_regs;
    t_accept;
    t_block;
    t_arb;
    t_soft;
    t_spec;
    final_report;
  end
  // The run needs well under a thousand cycles; the limit leaves ample margin.
  initial begin
    #400000;
    fail_count++;
    final_report;
  end
endmodule
